// ==== rtl/scg_mode_table.sv ====
// Combinational table of running clocks and armed wake sources per mode.
// Assumes mode is one of the four valid encodings whenever sleeping is high.
`timescale 1ns/1ps
module scg_mode_table
    import scg_pkg::*;
(
    // Selection
    input wire logic sleeping,
    input wire logic [2:0] mode,
    // Clock domains
    output logic core_en,
    output logic mem_en,
    output logic io_en,
    output logic conv_en,
    output logic pll_en,
    output logic osc_en,
    // Armed wake sources
    output logic [SCG_WK_W-1:0] wake_mask
);
    always_comb begin
        core_en = 1'b0;
        mem_en = 1'b0;
        io_en = 1'b0;
        conv_en = 1'b0;
        pll_en = 1'b0;
        osc_en = 1'b0;
        wake_mask = '0;
        if (!sleeping) begin
            core_en = 1'b1;
            mem_en = 1'b1;
            io_en = 1'b1;
            conv_en = 1'b1;
            pll_en = 1'b1;
            osc_en = 1'b1;
        end else begin
            case (mode)
                SCG_MODE_IDLE: begin
                    io_en = 1'b1;
                    conv_en = 1'b1;
                    pll_en = 1'b1;
                    osc_en = 1'b1;
                    wake_mask = '1;
                end
                SCG_MODE_NOISE: begin
                    conv_en = 1'b1;
                    pll_en = 1'b1;
                    osc_en = 1'b1;
                    wake_mask[SCG_WK_LEVEL] = 1'b1;
                    wake_mask[SCG_WK_PSC] = 1'b1;
                    wake_mask[SCG_WK_MEMRDY] = 1'b1;
                    wake_mask[SCG_WK_CONV] = 1'b1;
                    wake_mask[SCG_WK_WDT] = 1'b1;
                end
                SCG_MODE_PDOWN: begin
                    wake_mask[SCG_WK_LEVEL] = 1'b1;
                    wake_mask[SCG_WK_PSC] = 1'b1;
                    wake_mask[SCG_WK_WDT] = 1'b1;
                end
                SCG_MODE_STANDBY: begin
                    osc_en = 1'b1;
                    wake_mask[SCG_WK_LEVEL] = 1'b1;
                    wake_mask[SCG_WK_WDT] = 1'b1;
                end
                default: begin
                    wake_mask = '0;
                end
            endcase
        end
    end
endmodule // scg_mode_table

// ==== rtl/scg_pkg.sv ====
// Constants, register map and encodings for the sleep clock gating block.
// Assumes a 32-bit APB register bus and a single system clock.
package scg_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] SCG_OFS_SLEEP_CTRL = 8'h00;
    localparam logic [7:0] SCG_OFS_PCG = 8'h04;
    localparam logic [7:0] SCG_OFS_INPUT_DISABLE_REG_0 = 8'h08;
    localparam logic [7:0] SCG_OFS_INPUT_DISABLE_REG_1 = 8'h0c;
    localparam logic [7:0] SCG_OFS_STATUS = 8'h10;

    // Sleep control fields
    localparam int SCG_SE_BIT = 0;
    localparam int SCG_MODE_LSB = 1;
    localparam int SCG_MODE_MSB = 3;

    // Reset values
    localparam logic [7:0] SCG_PCG_RST = 8'h00;
    localparam logic [7:0] SCG_DIDR_RST = 8'h00;
    localparam logic [2:0] SCG_MODE_RST = 3'h0;

    // Sleep mode select encodings; other codes are reserved
    localparam logic [2:0] SCG_MODE_IDLE = 3'h0;
    localparam logic [2:0] SCG_MODE_NOISE = 3'h1;
    localparam logic [2:0] SCG_MODE_PDOWN = 3'h2;
    localparam logic [2:0] SCG_MODE_STANDBY = 3'h6;

    // Peripheral clock gate bit positions
    localparam int SCG_GATE_CONV = 0;
    localparam int SCG_GATE_SERIAL = 1;
    localparam int SCG_GATE_SPI = 2;
    localparam int SCG_GATE_TIMER0 = 3;
    localparam int SCG_GATE_TIMER1 = 4;
    localparam int SCG_GATE_PSC0 = 5;
    localparam int SCG_GATE_PSC1 = 6;
    localparam int SCG_GATE_PSC2 = 7;

    // Wake source vector positions
    localparam int SCG_WK_LEVEL = 0;
    localparam int SCG_WK_EDGE = 1;
    localparam int SCG_WK_PSC = 2;
    localparam int SCG_WK_MEMRDY = 3;
    localparam int SCG_WK_CONV = 4;
    localparam int SCG_WK_WDT = 5;
    localparam int SCG_WK_OTHER = 6;
    localparam int SCG_WK_W = 7;

    // Wake timing in clock cycles
    localparam int SCG_HALT_CYC = 4;
    localparam int SCG_STANDBY_WAKE_CYC = 6;

    // Brown-out fuse code that means detector off
    localparam logic [2:0] SCG_BOD_OFF_CODE = 3'h7;

    typedef enum logic [1:0] {
        SCG_ST_ACTIVE = 2'b00,
        SCG_ST_SLEEP = 2'b01,
        SCG_ST_WAKE = 2'b10
    } scg_state_t;

    function automatic logic scg_mode_valid(input logic [2:0] m);
        return (m == SCG_MODE_IDLE) || (m == SCG_MODE_NOISE) ||
               (m == SCG_MODE_PDOWN) || (m == SCG_MODE_STANDBY);
    endfunction

endpackage

// ==== rtl/scg_sync.sv ====
// Two flip-flop synchroniser for a bundle of slow levels.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
module scg_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // scg_sync

// ==== rtl/scg_top.sv ====
// Sleep mode sequencing, clock domain gating and per-peripheral clock shutdown.
// Assumes an APB master on pclk, core sleep requests as one-cycle pulses on
// pclk, and external interrupt pins and fuses arriving asynchronously.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps

// Overview of operation
// (RULE1) Mode 110 with crystal enters standby
// (RULE2) Standby equals power-down, oscillator kept running; here standby also leaves the PSC wake source unarmed
// (RULE3) Standby wake resumes after six cycles
// (RULE4) Each sleep mode stops its own clocks
// (RULE5) Each sleep mode arms its wake sources
// (RULE6) Gate bit stops clock, blocks register access
// (RULE7) Clearing gate bit restarts clock, state kept
// (RULE8) Gate register eight bits, reset zero
// (RULE9) Peripheral gating matters in active, idle only; here the converter gate bit also acts in SCG_MODE_NOISE
// (RULE10) Enabled timers keep running despite gate bit
// (RULE11) Software reinitialises serial and stage modules
// (RULE12) Software disables converter before gating it
// (RULE13) Gated converter clock blocks comparator mux
// (RULE14) Converter stays enabled; restart gives extended conversion
// (RULE15) Deep sleep disables comparator unless using reference
// (RULE16) Fuse-enabled brown-out detector stays on
// (RULE17) Enabled watchdog keeps running in sleep
// (RULE18) Reference on only when a user needs it
// (RULE19) Deep sleep disables inputs except wake pins
// (RULE20) Software disables peripheral before gating clock
// (RULE21) Two registers disable analog pin input buffers
// (RULE22) Mode codes 000,001,010,110; others reserved
// (RULE23) Sleep needs enable bit; wake halts four plus startup
// (RULE24) Reserved mode sleep request does nothing
module scg_top
    import scg_pkg::*;
#(
    parameter int STARTUP_CYCLES = 16,
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core handshake
    input wire logic sleep_instr,
    output logic core_resume,
    output logic core_sleeping,
    // Wake sources
    input wire logic [3:0] external_irq_lines_n,
    input wire logic [3:0] ext_level_en,
    input wire logic ext_edge_evt,
    input wire logic psc_irq,
    input wire logic mem_ready_irq,
    input wire logic conv_irq,
    input wire logic wdt_irq,
    input wire logic other_io_irq,
    // Fuses and peripheral status
    input wire logic xtal_option,
    input wire logic [2:0] brownout_level_fuses,
    input wire logic conv_enable,
    input wire logic conv_start,
    input wire logic acmp_enable,
    input wire logic acmp_uses_vref,
    input wire logic timer0_enabled,
    input wire logic timer1_enabled,
    input wire logic wdt_enable,
    // Clock domain enables
    output logic core_clock_en,
    output logic program_mem_clock_en,
    output logic io_clock_en,
    output logic converter_clock_en,
    output logic fast_pll_clock_en,
    output logic main_osc_en,
    // Peripheral gating
    output logic [7:0] periph_clk_en,
    output logic [7:0] periph_access_en,
    // Analog and pin control
    output logic acmp_mux_allow,
    output logic acmp_force_off,
    output logic conv_keep_en,
    output logic conv_extended_next,
    output logic brownout_en,
    output logic wdt_run_en,
    output logic vref_en,
    output logic input_buf_en,
    output logic [3:0] wake_pin_buf_en,
    output logic [15:0] dig_in_disable
);
    localparam logic [CNT_W-1:0] CNT_STANDBY = CNT_W'(SCG_STANDBY_WAKE_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_HALT = CNT_W'(SCG_HALT_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_PDOWN = CNT_W'(SCG_HALT_CYC + STARTUP_CYCLES - 1);

    // Synchronised pins and fuses
    logic [7:0] sync_in;
    logic [7:0] sync_out;
    logic [3:0] ext_irq_n_s;
    logic [2:0] bod_fuse_s;
    logic xtal_s;

    assign sync_in = {xtal_option, brownout_level_fuses, external_irq_lines_n};
    assign ext_irq_n_s = sync_out[3:0];
    assign bod_fuse_s = sync_out[6:4];
    assign xtal_s = sync_out[7];

    scg_sync #(
        .W(8)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(sync_in),
        .sync_out(sync_out)
    );

    // Registers
    logic sleep_en_q;
    logic [2:0] mode_sel_q;
    logic [7:0] pcg_q;
    logic [7:0] input_disable_reg_0_q;
    logic [7:0] input_disable_reg_1_q;
    scg_state_t state_q;
    scg_state_t state_d;
    logic [2:0] act_mode_q;
    logic [2:0] act_mode_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic conv_en_prev_q;
    logic conv_ext_q;

    // APB decode
    logic apb_wr;
    logic apb_setup;
    logic lane0_wr;

    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite && pready;
    assign lane0_wr = apb_wr && pstrb[0];

    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == SCG_OFS_SLEEP_CTRL) || (a == SCG_OFS_PCG) || (a == SCG_OFS_INPUT_DISABLE_REG_0) ||
               (a == SCG_OFS_INPUT_DISABLE_REG_1) || (a == SCG_OFS_STATUS);
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_en_q <= 1'b0;
            mode_sel_q <= SCG_MODE_RST;
        end else if (lane0_wr && paddr == SCG_OFS_SLEEP_CTRL) begin
            sleep_en_q <= pwdata[SCG_SE_BIT];
            mode_sel_q <= pwdata[SCG_MODE_MSB:SCG_MODE_LSB];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcg_q <= SCG_PCG_RST; // [RULE8]
        end else if (lane0_wr && paddr == SCG_OFS_PCG) begin
            pcg_q <= pwdata[7:0]; // [RULE8]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_disable_reg_0_q <= SCG_DIDR_RST;
            input_disable_reg_1_q <= SCG_DIDR_RST;
        end else if (lane0_wr) begin
            if (paddr == SCG_OFS_INPUT_DISABLE_REG_0) begin
                input_disable_reg_0_q <= pwdata[7:0]; // [RULE21]
            end
            if (paddr == SCG_OFS_INPUT_DISABLE_REG_1) begin
                input_disable_reg_1_q <= pwdata[7:0]; // [RULE21]
            end
        end
    end

    // Read data is captured in the setup cycle and held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (apb_setup) begin
                pslverr <= !addr_mapped(paddr);
                prdata <= '0;
                if (!pwrite) begin
                    case (paddr)
                        SCG_OFS_SLEEP_CTRL: prdata[SCG_MODE_MSB:0] <= {mode_sel_q, sleep_en_q};
                        SCG_OFS_PCG: prdata[7:0] <= pcg_q;
                        SCG_OFS_INPUT_DISABLE_REG_0: prdata[7:0] <= input_disable_reg_0_q;
                        SCG_OFS_INPUT_DISABLE_REG_1: prdata[7:0] <= input_disable_reg_1_q;
                        SCG_OFS_STATUS: prdata[7:0] <= {vref_en, brownout_en, conv_ext_q, act_mode_q, state_q};
                        default: prdata <= '0;
                    endcase
                end
            end
        end
    end

    // Mode table driven by next state so enables align with the state
    logic sleeping_d;
    logic tbl_core;
    logic tbl_mem;
    logic tbl_io;
    logic tbl_conv;
    logic tbl_pll;
    logic tbl_osc;
    logic [SCG_WK_W-1:0] tbl_mask;
    logic [SCG_WK_W-1:0] cur_mask;
    logic [SCG_WK_W-1:0] wake_src;
    logic wake_hit;

    assign sleeping_d = state_d != SCG_ST_ACTIVE;

    scg_mode_table u_tbl_next (
        .sleeping(sleeping_d),
        .mode(act_mode_d),
        .core_en(tbl_core),
        .mem_en(tbl_mem),
        .io_en(tbl_io),
        .conv_en(tbl_conv),
        .pll_en(tbl_pll),
        .osc_en(tbl_osc),
        .wake_mask()
    );

    scg_mode_table u_tbl_cur (
        .sleeping(1'b1),
        .mode(act_mode_q),
        .core_en(),
        .mem_en(),
        .io_en(),
        .conv_en(),
        .pll_en(),
        .osc_en(),
        .wake_mask(tbl_mask)
    );

    always_comb begin
        wake_src = '0;
        wake_src[SCG_WK_LEVEL] = |(~ext_irq_n_s & ext_level_en);
        wake_src[SCG_WK_EDGE] = ext_edge_evt;
        wake_src[SCG_WK_PSC] = psc_irq;
        wake_src[SCG_WK_MEMRDY] = mem_ready_irq;
        wake_src[SCG_WK_CONV] = conv_irq;
        wake_src[SCG_WK_WDT] = wdt_irq;
        wake_src[SCG_WK_OTHER] = other_io_irq;
    end

    assign cur_mask = tbl_mask; // [RULE5]
    assign wake_hit = |(wake_src & cur_mask); // [RULE5]

    // Sleep sequencer
    always_comb begin
        state_d = state_q;
        act_mode_d = act_mode_q;
        cnt_d = cnt_q;
        case (state_q)
            SCG_ST_ACTIVE: begin
                // Reserved codes and a cleared enable leave the core running
                if (sleep_instr && sleep_en_q && scg_mode_valid(mode_sel_q)) begin // [RULE23] [RULE24] [RULE22]
                    state_d = SCG_ST_SLEEP;
                    act_mode_d = mode_sel_q;
                    if (mode_sel_q == SCG_MODE_STANDBY && !xtal_s) begin
                        act_mode_d = SCG_MODE_PDOWN; // [RULE1]
                    end
                end
            end
            SCG_ST_SLEEP: begin
                if (wake_hit) begin
                    state_d = SCG_ST_WAKE;
                    case (act_mode_q)
                        SCG_MODE_STANDBY: cnt_d = CNT_STANDBY; // [RULE3]
                        SCG_MODE_PDOWN: cnt_d = CNT_PDOWN; // [RULE23]
                        default: cnt_d = CNT_HALT; // [RULE23]
                    endcase
                end
            end
            SCG_ST_WAKE: begin
                if (cnt_q == '0) begin
                    state_d = SCG_ST_ACTIVE;
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            default: begin
                state_d = SCG_ST_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SCG_ST_ACTIVE;
            act_mode_q <= SCG_MODE_RST;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            act_mode_q <= act_mode_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_resume <= 1'b0;
            core_sleeping <= 1'b0;
        end else begin
            core_resume <= state_q == SCG_ST_WAKE && state_d == SCG_ST_ACTIVE;
            core_sleeping <= sleeping_d;
        end
    end

    // Clock domain enables; standby keeps the oscillator, power-down does not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_clock_en <= 1'b1;
            program_mem_clock_en <= 1'b1;
            io_clock_en <= 1'b1;
            converter_clock_en <= 1'b1;
            fast_pll_clock_en <= 1'b1;
            main_osc_en <= 1'b1;
        end else begin
            core_clock_en <= tbl_core; // [RULE4]
            program_mem_clock_en <= tbl_mem; // [RULE4]
            io_clock_en <= tbl_io; // [RULE4]
            converter_clock_en <= tbl_conv; // [RULE4]
            fast_pll_clock_en <= tbl_pll; // [RULE4]
            main_osc_en <= tbl_osc || state_d == SCG_ST_WAKE; // [RULE2] [RULE4]
        end
    end

    // Per-peripheral clock enables follow their domain and gate bit
    logic [7:0] periph_run_d;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_periph
            logic dom_on;
            logic hold;
            assign dom_on = (gi == SCG_GATE_CONV) ? tbl_conv : tbl_io; // [RULE9]
            assign hold = (gi == SCG_GATE_TIMER0) ? timer0_enabled :
                          (gi == SCG_GATE_TIMER1) ? timer1_enabled : 1'b0; // [RULE10]
            assign periph_run_d[gi] = dom_on && (!pcg_q[gi] || hold); // [RULE6] [RULE7]
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_clk_en <= '1;
            periph_access_en <= '1;
        end else begin
            periph_clk_en <= periph_run_d; // [RULE6] [RULE7] [RULE9]
            periph_access_en <= ~pcg_q; // [RULE6]
        end
    end

    // Converter restart tracking; the setting edge wins over a start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_en_prev_q <= 1'b0;
            conv_ext_q <= 1'b1;
        end else begin
            conv_en_prev_q <= conv_enable;
            if (conv_en_prev_q && !conv_enable) begin
                conv_ext_q <= 1'b1; // [RULE14]
            end else if (conv_start) begin
                conv_ext_q <= 1'b0;
            end
        end
    end

    // Analog, supervisor and pin buffer controls
    logic deep_d;
    logic io_or_conv_d;

    assign deep_d = sleeping_d && act_mode_d != SCG_MODE_IDLE && act_mode_d != SCG_MODE_NOISE;
    assign io_or_conv_d = tbl_io || tbl_conv;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acmp_mux_allow <= 1'b1;
            acmp_force_off <= 1'b0;
            conv_keep_en <= 1'b0;
            conv_extended_next <= 1'b1;
            brownout_en <= 1'b0;
            wdt_run_en <= 1'b0;
            vref_en <= 1'b0;
        end else begin
            acmp_mux_allow <= tbl_conv && !pcg_q[SCG_GATE_CONV]; // [RULE13]
            acmp_force_off <= deep_d && !acmp_uses_vref; // [RULE15]
            conv_keep_en <= conv_enable; // [RULE14]
            conv_extended_next <= conv_ext_q; // [RULE14]
            brownout_en <= bod_fuse_s != SCG_BOD_OFF_CODE; // [RULE16]
            wdt_run_en <= wdt_enable; // [RULE17]
            vref_en <= (bod_fuse_s != SCG_BOD_OFF_CODE) || (acmp_enable && acmp_uses_vref) ||
                       conv_enable; // [RULE18]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_buf_en <= 1'b1;
            wake_pin_buf_en <= '1;
            dig_in_disable <= '0;
        end else begin
            input_buf_en <= io_or_conv_d; // [RULE19]
            wake_pin_buf_en <= io_or_conv_d ? 4'hf : ext_level_en; // [RULE19]
            dig_in_disable <= {input_disable_reg_1_q, input_disable_reg_0_q}; // [RULE21]
        end
    end

endmodule // scg_top

// ==== sim/scg_far_model.sv ====
// Gated peripherals: each holds a state counter that advances only on its clock.
// Assumes periph_clk_en from the block under test, bit order as the gate register.
`timescale 1ns/1ps
module scg_far_model
    import scg_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Gating
    input wire logic [7:0] periph_clk_en,
    // Observed state
    output logic [63:0] state_q
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (periph_clk_en[i]) begin
                    state_q[i*8 +: 8] <= state_q[i*8 +: 8] + 8'h01;
                end
            end
        end
    end
endmodule // scg_far_model

// ==== sim/scg_top_sva.sv ====
// Checker for the sleep clock gating top: clock domains, wake pulse, gating.
// Assumes it is bound into scg_top and sees only that module's ports.
`timescale 1ns/1ps
module scg_top_sva (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // Core and status
    input wire logic sleep_instr,
    input wire logic core_resume,
    input wire logic core_sleeping,
    input wire logic wdt_enable,
    input wire logic conv_enable,
    // Outputs under check
    input wire logic core_clock_en,
    input wire logic program_mem_clock_en,
    input wire logic io_clock_en,
    input wire logic converter_clock_en,
    input wire logic fast_pll_clock_en,
    input wire logic main_osc_en,
    input wire logic [7:0] periph_access_en,
    input wire logic wdt_run_en,
    input wire logic conv_keep_en,
    input wire logic input_buf_en
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_gate_access: assert property (psel && penable && pwrite && paddr == 8'h04
        |-> ##2 periph_access_en == ~$past(pwdata[7:0], 2)) else $error("gate access mismatch");
    a_enter_cause: assert property ($rose(core_sleeping) |-> $past(sleep_instr))
        else $error("sleep without request");
    a_resume_pulse: assert property (core_resume |-> core_clock_en && !core_sleeping ##1 !core_resume)
        else $error("resume pulse wrong");
    a_sleep_core_off: assert property (core_sleeping |-> !core_clock_en && !program_mem_clock_en)
        else $error("core clock on in sleep");
    a_deep_clocks: assert property (core_sleeping && !main_osc_en
        |-> !io_clock_en && !converter_clock_en && !fast_pll_clock_en) else $error("deep sleep clock on");
    a_input_buf: assert property (!io_clock_en && !converter_clock_en |-> !input_buf_en)
        else $error("input buffers on");
    a_wdt_keep: assert property (wdt_enable |=> wdt_run_en)
        else $error("watchdog stopped");
    a_conv_keep: assert property (conv_enable |=> conv_keep_en)
        else $error("converter dropped");
endmodule // scg_top_sva

bind scg_top scg_top_sva u_sva (.*);

// ==== sim/sleep_clock_gating_control_test.sv ====
// Self-checking bench: APB register access, sleep entry and wake, clock gating.
// Assumes scg_top with a short startup count and the peripheral model beside it.
`timescale 1ns/1ps
module sleep_clock_gating_control_test
    import scg_pkg::*;
;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf, external_irq_lines_n = 4'hf, ext_level_en = 4'h0, wake_pin_buf_en;
    logic sleep_instr = 1'h0, ext_edge_evt = 1'h0, psc_irq = 1'h0, mem_ready_irq = 1'h0, conv_irq = 1'h0;
    logic wdt_irq = 1'h0, other_io_irq = 1'h0, xtal_option = 1'h1, conv_enable = 1'h0, conv_start = 1'h0;
    logic acmp_enable = 1'h0, acmp_uses_vref = 1'h0, timer0_enabled = 1'h0, timer1_enabled = 1'h1;
    logic wdt_enable = 1'h1, pready, pslverr, er, core_resume, core_sleeping, core_clock_en;
    logic program_mem_clock_en, io_clock_en, converter_clock_en, fast_pll_clock_en, main_osc_en;
    logic acmp_mux_allow, acmp_force_off, conv_keep_en, conv_extended_next, brownout_en, wdt_run_en;
    logic vref_en, input_buf_en;
    logic [2:0] brownout_level_fuses = 3'h7;
    logic [7:0] periph_clk_en, periph_access_en, s;
    logic [15:0] dig_in_disable;
    logic [63:0] state_q;
    int err_count = 0;
    int check_count = 0;

    scg_top #(.STARTUP_CYCLES(3)) u_dut (.*);
    scg_far_model u_far (.*);

    initial begin
        forever #5 pclk = ~pclk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            err_count++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic pulse;
        @(posedge pclk);
        sleep_instr <= 1'h1;
        @(posedge pclk);
        sleep_instr <= 1'h0;
        @(negedge pclk);
    endtask

    // Unarmed sources must not wake; the watchdog then wakes after the mode's count
    task automatic sleep_wake(input logic [2:0] m, input logic [5:0] ck, input logic [5:0] off, input int w);
        int n;
        apb(1'h1, SCG_OFS_SLEEP_CTRL, {28'h0, m, 1'h1});
        pulse();
        chk({core_clock_en, program_mem_clock_en, io_clock_en, converter_clock_en, fast_pll_clock_en,
            main_osc_en}, ck);
        @(posedge pclk);
        {other_io_irq, wdt_irq, conv_irq, mem_ready_irq, psc_irq, ext_edge_evt} <= off;
        repeat (3) @(negedge pclk);
        chk({core_sleeping, acmp_force_off, input_buf_en, wake_pin_buf_en},
            {1'h1, m[1], {5{!m[1]}}});
        @(posedge pclk);
        {other_io_irq, wdt_irq, conv_irq, mem_ready_irq, psc_irq, ext_edge_evt} <= 6'h10;
        n = -1;
        do begin
            @(negedge pclk);
            n++;
        end while (core_resume !== 1'h1 && n < 200);
        chk(n, w);
        @(posedge pclk);
        wdt_irq <= 1'h0;
        $display("sleep mode %h done", m);
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, SCG_OFS_PCG, 32'h0);
        chk(rd, 32'h0);
        chk(periph_access_en, 8'hff);
        apb(1'h1, SCG_OFS_PCG, 32'hb5);
        repeat (3) @(negedge pclk);
        chk(periph_access_en, 8'h4a);
        chk(periph_clk_en, 8'h5a);
        chk(acmp_mux_allow, 1'h0);
        s = state_q[63:56];
        repeat (4) @(negedge pclk);
        chk(state_q[63:56], s);
        apb(1'h0, SCG_OFS_PCG, 32'h0);
        chk(rd, 32'hb5);
        apb(1'h1, SCG_OFS_PCG, 32'h0);
        repeat (3) @(negedge pclk);
        s = state_q[63:56];
        repeat (5) @(negedge pclk);
        chk(state_q[63:56], s + 8'h05);
        apb(1'h0, 8'h14, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        apb(1'h1, SCG_OFS_INPUT_DISABLE_REG_0, 32'h3c);
        apb(1'h1, SCG_OFS_INPUT_DISABLE_REG_1, 32'hc3);
        repeat (2) @(negedge pclk);
        chk(dig_in_disable, 16'hc33c);
        chk({brownout_en, vref_en}, 2'h0);
        @(posedge pclk);
        brownout_level_fuses <= 3'h2;
        acmp_enable <= 1'h1;
        conv_enable <= 1'h1;
        conv_start <= 1'h1;
        @(posedge pclk);
        conv_start <= 1'h0;
        repeat (4) @(negedge pclk);
        chk({brownout_en, vref_en, conv_extended_next}, 3'h6);
        $display("register test done");
        apb(1'h1, SCG_OFS_SLEEP_CTRL, 32'h7);
        pulse();
        chk(core_sleeping, 1'h0);
        apb(1'h1, SCG_OFS_SLEEP_CTRL, 32'h0);
        pulse();
        chk(core_sleeping, 1'h0);
        sleep_wake(SCG_MODE_IDLE, 6'h0f, 6'h00, 5);
        sleep_wake(SCG_MODE_NOISE, 6'h07, 6'h21, 5);
        sleep_wake(SCG_MODE_PDOWN, 6'h00, 6'h2d, 8);
        sleep_wake(SCG_MODE_STANDBY, 6'h01, 6'h2f, 7);
        @(posedge pclk);
        conv_enable <= 1'h0;
        repeat (3) @(negedge pclk);
        chk(conv_extended_next, 1'h1);
        $display("converter test done");
        end_sim();
    end
endmodule // sleep_clock_gating_control_test
